/* design/profile_position_sequencer.sv */
// Decided for this implementation: the strobed register port and the placing of the registers.
`timescale 1ns/100ps
// Summary of operation
// - master loads target then sets new-setpoint bit; device starts a move.
// - change-now set: a new setpoint during a move replaces it at once.
// - change-now clear: a new setpoint during a move waits until it finishes.
// - push bit at acceptance runs a push move at profile velocity.
// - load contact during a push sets the load-contact flag.
// - halt or external stop while pushing with load contact flagged stops motion and cancels push.
// - push reaching target without contact finishes normally, flag stays zero.
// - wrap bit selects wrap positioning (variant from wrap mode) and ignores abs/rel bit.
// - without wrap, abs/rel picks absolute or incremental; base bit picks origin.
// - with wrap, wrap mode picks absolute, shortest, forward or reverse.
// - wrap and push together run push form of chosen wrap variant.
// - absolute target is a coordinate from home.
// - incremental command-based end point is command position plus distance.
// - incremental actual-based end point is actual position plus distance.
// - acknowledge rises on accepted start, falls on bit low or enable loss.
// - target reached only on proper completion, not on interruption.
module profile_position_sequencer
    import pp_seq_pkg::*;
(
    input wire logic clock, // 50 MHz control clock
    input wire logic srst, // synchronous reset, active high
    input wire pp_seq_pkg::reg_req_t req, // register bus request
    output logic [31:0] rdata, // read data, one cycle after read
    input wire logic op_enabled, // drive state machine in operation enabled
    input wire logic [31:0] command_pos, // present command position
    input wire logic [31:0] actual_pos, // present actual position
    input wire logic stop_pin, // external stop input, asynchronous
    input wire logic motion_done, // profile generator reached end point
    input wire logic contact_det, // deviation shows load pressed
    output logic move_start, // pulse: launch move_cmd
    output pp_seq_pkg::move_cmd_t move_cmd, // command to profile generator
    output logic move_abort, // pulse: stop present motion
    output logic irq // level interrupt
);
    import pp_seq_pkg::*;

    // ------------------------------------------------------------
    // registers and synchronisers
    // ------------------------------------------------------------
    logic [15:0] control_q;
    logic [31:0] target_q;
    logic [1:0] wrap_mode_q;
    logic stop_s1_q, stop_s2_q;
    logic nsp_prev_q;
    logic busy_q, pending_q, pushing_q;
    move_cmd_t pend_q;
    logic ack_q, reached_q, contact_q;
    logic [IRQ_BITS-1:0] irq_stat_q, irq_en_q;

    // stop pin passes two flops before use
    always_ff @(posedge clock) begin
        if (srst) begin
            stop_s1_q <= 1'b0;
            stop_s2_q <= 1'b0;
        end else begin
            stop_s1_q <= stop_pin;
            stop_s2_q <= stop_s1_q;
        end
    end

    // ------------------------------------------------------------
    // command decode
    // ------------------------------------------------------------
    wire nsp = control_q[CW_NEW_SETPOINT];
    wire halt = control_q[CW_HALT];
    wire wr_control = req.wr && req.addr == REG_CONTROL;
    wire start_edge = nsp && !nsp_prev_q && op_enabled;
    wire stop_req = halt || stop_s2_q;
    variant_t variant;
    logic [31:0] end_point;
    move_cmd_t new_cmd;

    // variant select from control word and wrap mode
    always_comb begin
        if (control_q[CW_WRAP]) begin
            unique case (wrap_mode_q)
                WRAP_ABSOLUTE: variant = VAR_WRAP_ABSOLUTE;
                WRAP_SHORTEST: variant = VAR_WRAP_SHORTEST;
                WRAP_FORWARD: variant = VAR_WRAP_FORWARD;
                WRAP_REVERSE: variant = VAR_WRAP_REVERSE;
            endcase
        end else if (!control_q[CW_ABS_REL]) begin
            variant = VAR_ABSOLUTE;
        end else if (control_q[CW_BASE_ACTUAL]) begin
            variant = VAR_INC_ACTUAL;
        end else begin
            variant = VAR_INC_COMMAND;
        end
    end

    // end point: coordinate or base plus distance
    always_comb begin
        unique case (variant)
            VAR_INC_COMMAND: end_point = command_pos + target_q;
            VAR_INC_ACTUAL: end_point = actual_pos + target_q;
            default: end_point = target_q;
        endcase
    end

    assign new_cmd = '{push: control_q[CW_PUSH], variant: variant, end_point: end_point};

    wire replace = start_edge && busy_q && control_q[CW_CHANGE_NOW];
    wire queue = start_edge && busy_q && !control_q[CW_CHANGE_NOW] && !(motion_done && !pending_q);
    wire launch_new = start_edge && (!busy_q || (motion_done && !pending_q && !control_q[CW_CHANGE_NOW]));
    wire launch_pend = busy_q && motion_done && pending_q && !replace;
    wire push_cancel = pushing_q && contact_q && stop_req;
    wire finish = busy_q && motion_done && !pending_q && !replace;

    // ------------------------------------------------------------
    // move sequencing
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            nsp_prev_q <= 1'b0;
            busy_q <= 1'b0;
            pending_q <= 1'b0;
            pushing_q <= 1'b0;
            pend_q <= '0;
            move_cmd <= '0;
            move_start <= 1'b0;
            move_abort <= 1'b0;
        end else begin
            nsp_prev_q <= nsp;
            move_start <= 1'b0;
            move_abort <= 1'b0;
            if (!op_enabled || push_cancel) begin
                busy_q <= 1'b0;
                pending_q <= 1'b0;
                pushing_q <= 1'b0;
                move_abort <= busy_q;
            end else if (launch_new || replace) begin
                busy_q <= 1'b1;
                pending_q <= 1'b0;
                pushing_q <= new_cmd.push;
                move_cmd <= new_cmd;
                move_start <= 1'b1;
                move_abort <= replace;
            end else if (launch_pend) begin
                pending_q <= queue;
                if (queue) pend_q <= new_cmd;
                pushing_q <= pend_q.push;
                move_cmd <= pend_q;
                move_start <= 1'b1;
            end else begin
                if (queue) begin
                    pending_q <= 1'b1;
                    pend_q <= new_cmd;
                end
                if (finish) begin
                    busy_q <= 1'b0;
                    pushing_q <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // status flags
    // ------------------------------------------------------------
    always_ff @(posedge clock) begin
        if (srst) begin
            ack_q <= 1'b0;
            reached_q <= 1'b0;
            contact_q <= 1'b0;
        end else begin
            if (!nsp || !op_enabled) begin
                ack_q <= 1'b0;
            end else if (start_edge) begin
                ack_q <= 1'b1;
            end
            if (move_start || !op_enabled || push_cancel) begin
                reached_q <= 1'b0;
            end else if (finish) begin
                reached_q <= 1'b1;
            end
            if (!pushing_q || move_start || push_cancel) begin
                contact_q <= 1'b0;
            end else if (contact_det) begin
                contact_q <= 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // interrupts and register bus
    // ------------------------------------------------------------
    logic [IRQ_BITS-1:0] irq_ev;
    assign irq_ev[IRQ_START] = move_start;
    assign irq_ev[IRQ_DONE] = finish;
    assign irq_ev[IRQ_CONTACT] = pushing_q && contact_det && !contact_q;
    assign irq_ev[IRQ_CANCEL] = push_cancel;
    wire [IRQ_BITS-1:0] irq_clr = (req.wr && req.addr == REG_IRQ_CLEAR) ? req.wdata[IRQ_BITS-1:0] : '0;

    logic [15:0] status_word;
    always_comb begin
        status_word = '0;
        status_word[SW_TARGET_REACHED] = reached_q;
        status_word[SW_SETPOINT_ACK] = ack_q;
        status_word[SW_LOAD_CONTACT] = contact_q;
    end

    logic [31:0] rd_mux;
    always_comb begin
        unique case (req.addr)
            REG_CONTROL: rd_mux = {16'h0000, control_q};
            REG_TARGET: rd_mux = target_q;
            REG_WRAP_MODE: rd_mux = {30'h0, wrap_mode_q};
            REG_STATUS: rd_mux = {16'h0000, status_word};
            REG_END_POINT: rd_mux = move_cmd.end_point;
            REG_VARIANT: rd_mux = {28'h0000000, move_cmd.push, move_cmd.variant};
            REG_IRQ_STATUS: rd_mux = {28'h0000000, irq_stat_q};
            REG_IRQ_ENABLE: rd_mux = {28'h0000000, irq_en_q};
            default: rd_mux = 32'h00000000;
        endcase
    end

    // register writes, sticky events (set beats clear), read data
    always_ff @(posedge clock) begin
        if (srst) begin
            control_q <= 16'h0000;
            target_q <= 32'h00000000;
            wrap_mode_q <= WRAP_ABSOLUTE;
            irq_stat_q <= '0;
            irq_en_q <= '0;
            irq <= 1'b0;
            rdata <= 32'h00000000;
        end else begin
            if (wr_control) control_q <= req.wdata[15:0];
            if (req.wr && req.addr == REG_TARGET) target_q <= req.wdata;
            if (req.wr && req.addr == REG_WRAP_MODE) wrap_mode_q <= req.wdata[1:0];
            if (req.wr && req.addr == REG_IRQ_ENABLE) irq_en_q <= req.wdata[IRQ_BITS-1:0];
            irq_stat_q <= (irq_stat_q & ~irq_clr) | irq_ev;
            irq <= |(((irq_stat_q & ~irq_clr) | irq_ev) & irq_en_q);
            rdata <= req.rd ? rd_mux : 32'h00000000;
        end
    end

    // ------------------------------------------------------------
    // assertions
    // ------------------------------------------------------------
    a_edge_launch: assert property (@(posedge clock) disable iff (srst)
        start_edge && !busy_q |=> move_start && busy_q)
        else $error("idle rising setpoint did not launch");
    a_replace_now: assert property (@(posedge clock) disable iff (srst)
        op_enabled && !push_cancel && replace |=> move_start && move_abort)
        else $error("immediate change did not replace move");
    a_queue_hold: assert property (@(posedge clock) disable iff (srst)
        op_enabled && !push_cancel && queue && !motion_done |=> pending_q && !move_start)
        else $error("queued setpoint started early");
    a_push_cancel: assert property (@(posedge clock) disable iff (srst)
        push_cancel |=> !pushing_q && !contact_q && move_abort)
        else $error("stop during contact did not cancel push");
    a_contact_push: assert property (@(posedge clock) disable iff (srst)
        contact_q |-> $past(pushing_q))
        else $error("contact flag outside push");
    a_hold_nsp: assert property (@(posedge clock) disable iff (srst)
        nsp && $past(nsp) && !busy_q |=> !move_start)
        else $error("held setpoint bit restarted move");
    a_ack_drop: assert property (@(posedge clock) disable iff (srst)
        !nsp |=> !ack_q)
        else $error("acknowledge stayed with bit low");
    a_reached_done: assert property (@(posedge clock) disable iff (srst)
        $rose(reached_q) |-> $past(finish))
        else $error("target reached without completion");
    a_wrap_abs: assert property (@(posedge clock) disable iff (srst)
        control_q[CW_WRAP] && wrap_mode_q == WRAP_ABSOLUTE |-> end_point == target_q)
        else $error("wrap absolute used relative end point");

    // flag, enable and pulse checks
    a_ack_rise: assert property (@(posedge clock) disable iff (srst)
        start_edge |=> ack_q)
        else $error("accepted start did not raise acknowledge");
    a_enable_drop: assert property (@(posedge clock) disable iff (srst)
        !op_enabled |=> !busy_q && !ack_q && !reached_q)
        else $error("enable loss left move or flags");
    a_contact_set: assert property (@(posedge clock) disable iff (srst)
        pushing_q && contact_det && !move_start && !push_cancel |=> contact_q)
        else $error("contact during push not flagged");
    a_done_reached: assert property (@(posedge clock) disable iff (srst)
        finish && op_enabled && !push_cancel && !move_start |=> reached_q)
        else $error("completed move not reported");
    a_abort_once: assert property (@(posedge clock) disable iff (srst)
        move_abort && !move_start |=> !move_abort)
        else $error("abort pulse longer than one cycle");
    a_queue_launch: assert property (@(posedge clock) disable iff (srst)
        op_enabled && !push_cancel && launch_pend |=> move_start && move_cmd == $past(pend_q))
        else $error("queued setpoint not started after completion");

    // main scenarios
    c_enable_drop: cover property (@(posedge clock) busy_q && !op_enabled);
    c_wrap_push: cover property (@(posedge clock) move_start && move_cmd.push && move_cmd.variant == VAR_WRAP_FORWARD);
    c_replace: cover property (@(posedge clock) replace);
    c_queue_run: cover property (@(posedge clock) queue ##[1:50] launch_pend);
    c_contact: cover property (@(posedge clock) $rose(contact_q));
    c_push_stop: cover property (@(posedge clock) push_cancel);
endmodule

/* design/pp_seq_pkg.sv */
package pp_seq_pkg;
    // control word bit positions
    localparam int CW_NEW_SETPOINT = 4;
    localparam int CW_CHANGE_NOW = 5;
    localparam int CW_ABS_REL = 6;
    localparam int CW_HALT = 8;
    localparam int CW_BASE_ACTUAL = 12;
    localparam int CW_PUSH = 13;
    localparam int CW_WRAP = 14;
    // status word bit positions
    localparam int SW_TARGET_REACHED = 10;
    localparam int SW_SETPOINT_ACK = 12;
    localparam int SW_LOAD_CONTACT = 15;
    // wrap positioning mode codes
    localparam logic [1:0] WRAP_ABSOLUTE = 2'h0;
    localparam logic [1:0] WRAP_SHORTEST = 2'h1;
    localparam logic [1:0] WRAP_FORWARD = 2'h2;
    localparam logic [1:0] WRAP_REVERSE = 2'h3;
    // register bus offsets
    localparam logic [3:0] REG_CONTROL = 4'h0;
    localparam logic [3:0] REG_TARGET = 4'h1;
    localparam logic [3:0] REG_WRAP_MODE = 4'h2;
    localparam logic [3:0] REG_STATUS = 4'h3;
    localparam logic [3:0] REG_END_POINT = 4'h4;
    localparam logic [3:0] REG_VARIANT = 4'h5;
    localparam logic [3:0] REG_IRQ_STATUS = 4'h6;
    localparam logic [3:0] REG_IRQ_ENABLE = 4'h7;
    localparam logic [3:0] REG_IRQ_CLEAR = 4'h8;
    // interrupt event bit positions
    localparam int IRQ_START = 0;
    localparam int IRQ_DONE = 1;
    localparam int IRQ_CONTACT = 2;
    localparam int IRQ_CANCEL = 3;
    localparam int IRQ_BITS = 4;

    // motion variant chosen at setpoint acceptance
    typedef enum logic [2:0] {
        VAR_ABSOLUTE,
        VAR_INC_COMMAND,
        VAR_INC_ACTUAL,
        VAR_WRAP_ABSOLUTE,
        VAR_WRAP_SHORTEST,
        VAR_WRAP_FORWARD,
        VAR_WRAP_REVERSE
    } variant_t;

    // one latched motion command
    typedef struct packed {
        logic push;
        variant_t variant;
        logic [31:0] end_point;
    } move_cmd_t;

    // register bus request
    typedef struct packed {
        logic [3:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } reg_req_t;
endpackage

/* testbench/motion_model.sv */
`timescale 1ns/100ps
module motion_model (
    input wire logic clock, // control clock
    input wire logic srst, // synchronous reset
    input wire logic move_start, // launch pulse
    input wire logic move_abort, // stop pulse
    input wire logic slow, // long move when high
    output logic motion_done // end point reached pulse
);
    logic [7:0] left_q;
    logic busy_q;
    // ----------
    // move timer
    // ----------
    // a start reloads the timer, an abort drops the move with no done pulse
    always_ff @(posedge clock) begin
        motion_done <= 1'b0;
        if (srst || (move_abort && !move_start)) begin
            busy_q <= 1'b0;
            left_q <= 8'h00;
        end else if (move_start) begin
            busy_q <= 1'b1;
            left_q <= slow ? 8'h28 : 8'h06;
        end else if (busy_q && left_q == 8'h00) begin
            busy_q <= 1'b0;
            motion_done <= 1'b1;
        end else if (busy_q) begin
            left_q <= left_q - 8'h01;
        end
    end
endmodule

/* testbench/tb.sv */
`timescale 1ns/100ps
`define CHK(nm, exp, got) begin n_compared++; if ((got) !== (exp)) begin miscompares++; \
    $display("Error %s expected %h seen %h", nm, exp, got); end end
module tb;
    import pp_seq_pkg::*;
    localparam logic [31:0] CMD_POS = 32'h0000_03e8;
    localparam logic [31:0] ACT_POS = 32'h0000_0384;
    localparam logic [31:0] TGT = 32'h0000_0bb8;
    logic clock = 1'b0;
    logic srst = 1'b1;
    reg_req_t req = '0;
    logic [31:0] rdata, rd_v;
    logic stop_pin = 1'b0, contact_det = 1'b0, slow = 1'b0, op_enabled = 1'b1;
    logic motion_done, move_start, move_abort, irq;
    move_cmd_t move_cmd, last_cmd;
    int miscompares = 0, n_compared = 0, n_start = 0, n_abort = 0, n_swap = 0;

    profile_position_sequencer profile_position_sequencer_i (.clock(clock), .srst(srst), .req(req), .rdata(rdata),
        .op_enabled(op_enabled), .command_pos(CMD_POS), .actual_pos(ACT_POS), .stop_pin(stop_pin),
        .motion_done(motion_done), .contact_det(contact_det), .move_start(move_start), .move_cmd(move_cmd),
        .move_abort(move_abort), .irq(irq));
    motion_model motion_model_i (.clock(clock), .srst(srst), .move_start(move_start), .move_abort(move_abort),
        .slow(slow), .motion_done(motion_done));

    // -------------
    // clock, monitor
    // -------------
    initial forever #10 clock = ~clock;
    // count launch and stop pulses mid-cycle, keep the last launched command
    always @(negedge clock) begin
        if (move_start) begin
            n_start++;
            last_cmd = move_cmd;
        end
        if (move_abort)
            n_abort++;
        if (move_start && move_abort)
            n_swap++;
    end

    // ---------
    // bus tasks
    // ---------
    task automatic wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clock);
        req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge clock);
        req.wr <= 1'b0;
    endtask
    task automatic rd(input logic [3:0] a);
        @(posedge clock);
        req <= '{addr: a, wdata: 32'h0, wr: 1'b0, rd: 1'b1};
        @(posedge clock);
        req.rd <= 1'b0;
        #1;
        rd_v = rdata;
    endtask
    task automatic settle(input int n);
        repeat (n) @(posedge clock);
    endtask
    // target first, then a rising new-setpoint bit
    task automatic go(input logic [15:0] cw, input logic [31:0] tgt);
        wr(REG_TARGET, tgt);
        wr(REG_CONTROL, {16'h0, cw});
        wr(REG_CONTROL, {16'h0, cw | 16'h0010});
        settle(4);
    endtask
    task automatic wait_done();
        int i;
        for (i = 0; i < 200 && !motion_done; i++) begin
            @(posedge clock);
            #1;
        end
        if (i == 200) begin
            miscompares++;
            complete_run();
        end
        settle(2);
    endtask
    task automatic complete_run();
        $display("compared %0d mismatches %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // ---------
    // scenarios
    // ---------
    // every variant, odd ones with push, wrap ones ignoring abs/rel
    task automatic variants();
        logic [15:0] cw [7] = '{16'h0000, 16'h0040, 16'h1040, 16'h4040, 16'h4040, 16'h4000, 16'h5040};
        logic [31:0] ep;
        int s;
        for (int i = 0; i < 7; i++) begin
            s = n_start;
            ep = (i == 1) ? CMD_POS + TGT : (i == 2) ? ACT_POS + TGT : TGT;
            wr(REG_WRAP_MODE, 32'((i + 1) % 4));
            go(cw[i] | (i[0] ? 16'h2000 : 16'h0000), TGT);
            `CHK("variant", variant_t'(i), last_cmd.variant)
            `CHK("push", i[0], last_cmd.push)
            `CHK("end_point", ep, last_cmd.end_point)
            rd(REG_STATUS);
            `CHK("ack", 1'b1, rd_v[SW_SETPOINT_ACK])
            wait_done();
            `CHK("starts", 1, n_start - s)
            rd(REG_STATUS);
            `CHK("reached", 1'b1, rd_v[SW_TARGET_REACHED])
            `CHK("contact", 1'b0, rd_v[SW_LOAD_CONTACT])
            wr(REG_CONTROL, 32'h0);
            rd(REG_STATUS);
            `CHK("ack_low", 1'b0, rd_v[SW_SETPOINT_ACK])
        end
    endtask
    // change-now: the second setpoint replaces the running move
    task automatic replace_move();
        int s;
        slow <= 1'b1;
        go(16'h0020, TGT);
        s = n_swap;
        go(16'h0020, 32'h0000_0123);
        `CHK("swap", 1, n_swap - s)
        `CHK("swap_end", 32'h0000_0123, last_cmd.end_point)
        rd(REG_STATUS);
        `CHK("not_reached", 1'b0, rd_v[SW_TARGET_REACHED])
        wait_done();
        wr(REG_CONTROL, 32'h0);
    endtask
    // no change-now: the second setpoint waits for the first to finish
    task automatic queue_move();
        int s;
        go(16'h0000, TGT);
        s = n_start;
        go(16'h0000, 32'h0000_0456);
        `CHK("held", 0, n_start - s)
        wait_done();
        `CHK("queued", 1, n_start - s)
        `CHK("queued_end", 32'h0000_0456, last_cmd.end_point)
        wait_done();
        wr(REG_CONTROL, 32'h0);
    endtask
    // push into a load, then halt bit or stop pin, with interrupt
    task automatic push_stop();
        int s;
        for (int k = 0; k < 2; k++) begin
            wr(REG_IRQ_ENABLE, 32'h0000_0004);
            go(16'h2000, TGT);
            contact_det <= 1'b1;
            settle(3);
            rd(REG_STATUS);
            `CHK("contact_set", 1'b1, rd_v[SW_LOAD_CONTACT])
            `CHK("irq_high", 1'b1, irq)
            s = n_abort;
            if (k == 0)
                wr(REG_CONTROL, 32'h0000_2110);
            else
                stop_pin <= 1'b1;
            settle(6);
            `CHK("abort", 1, n_abort - s)
            rd(REG_STATUS);
            `CHK("contact_clr", 1'b0, rd_v[SW_LOAD_CONTACT])
            rd(REG_IRQ_STATUS);
            `CHK("irq_cancel", 1'b1, rd_v[IRQ_CANCEL])
            wr(REG_IRQ_CLEAR, 32'h0000_000f);
            settle(2);
            `CHK("irq_low", 1'b0, irq)
            contact_det <= 1'b0;
            stop_pin <= 1'b0;
            wr(REG_CONTROL, 32'h0);
        end
        rd(4'hf);
        `CHK("unmapped", 32'h0, rd_v)
    endtask
    // losing operation enabled aborts the move and drops the flags
    task automatic enable_loss();
        int s;
        go(16'h0000, TGT);
        s = n_abort;
        op_enabled <= 1'b0;
        settle(2);
        `CHK("drop_abort", 1, n_abort - s)
        op_enabled <= 1'b1;
        rd(REG_STATUS);
        `CHK("drop_ack", 1'b0, rd_v[SW_SETPOINT_ACK])
        `CHK("drop_reached", 1'b0, rd_v[SW_TARGET_REACHED])
        wr(REG_CONTROL, 32'h0);
        settle(2);
    endtask

    initial begin
        repeat (10) @(posedge clock);
        srst <= 1'b0;
        variants();
        replace_move();
        queue_move();
        enable_loss();
        push_stop();
        complete_run();
    end
endmodule
